// ### bench/power_switch_model.sv
// System power switch and the open-drain request wire it watches
`timescale 1ns/1ps
`default_nettype none
module power_switch_model (
  // Request pin from the block
  input wire logic req_n_i,
  input wire logic req_oe_i,
  // Button contact from the bench
  input wire logic press_i,
  // System side
  output logic pin_level_o,
  output logic system_on_o,
  output logic button_off_o
);
  // Pull-up holds the wire high whenever the block lets go of it
  assign pin_level_o = req_oe_i ? req_n_i : 1'b1;
  assign system_on_o = ~pin_level_o;
  // No debounce modelled; the bench gives clean pulses
  assign button_off_o = press_i;
endmodule : power_switch_model
`default_nettype wire

// ### bench/soft_power_wake_test.sv
// Register-level bench for the soft-power wake block
`timescale 1ns/1ps
`default_nettype none
module soft_power_wake_test;
  import soft_power_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oe, req_n, irq;
  logic pin_level, system_on, button_off;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_v;
  logic [4:0] pins = 5'h1f;
  logic grp_a = 1'b0, grp_b = 1'b0, por = 1'b0, press = 1'b0;
  logic [7:0] sec_ev = 8'h00;
  int failures = 0;
  int total_checks = 0;
  int pos[EDGE_N] = '{BIT_RING1, BIT_RING2, BIT_KBD, BIT_MOUSE, BIT_IR_RX};
  logic [7:0] rst_idx[6] = '{IDX_ENABLE_FIRST, IDX_ENABLE_SECOND, IDX_STATUS_FIRST,
    IDX_STATUS_SECOND, IDX_IRQ_STATUS, IDX_IRQ_MASK};
  logic [7:0] rst_exp[6] = '{RST_ENABLE_FIRST, RST_ENABLE_SECOND, RST_STATUS, RST_STATUS,
    {5'h00, RST_IRQ}, {5'h00, RST_IRQ}};

  // 20 MHz clock
  always #25 core_clk_i = ~core_clk_i;

  soft_power_wake soft_power_wake_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .ring_ind_port1_event_i(pins[0]), .ring_ind_port2_event_i(pins[1]),
    .kbd_line_event_i(pins[2]), .mouse_line_event_i(pins[3]), .ir_rx_line_event_i(pins[4]),
    .group_int_a_i(grp_a), .group_int_b_i(grp_b), .wake_second_event_i(sec_ev),
    .standby_supply_por_i(por), .button_off_i(button_off),
    .power_on_request_n_o(req_n), .power_on_request_oe_o(oe), .irq_o(irq));

  power_switch_model power_switch_model_i (
    .req_n_i(req_n), .req_oe_i(oe), .press_i(press),
    .pin_level_o(pin_level), .system_on_o(system_on), .button_off_o(button_off));

  // Byte address of a register index
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ad

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk_i);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge core_clk_i);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read; pins in fall are pulled low so their edge lands on the AR edge
  task automatic rd(input logic [11:0] a, input logic [4:0] fall, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pins <= ~fall;
    do @(posedge core_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    pins <= 5'h1f;
    while (rvalid !== 1'b1) @(posedge core_clk_i);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic fall_pin(input int k);
    @(posedge core_clk_i);
    pins[k] <= 1'b0;
    @(posedge core_clk_i);
    pins[k] <= 1'b1;
  endtask : fall_pin

  // Registered outputs need a couple of edges to land
  task automatic settle;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask : settle

  task automatic push_button;
    @(posedge core_clk_i);
    press <= 1'b1;
    @(posedge core_clk_i);
    press <= 1'b0;
    settle();
  endtask : push_button

  // Program the power-up policy, then pulse the standby reset
  task automatic por_case(input logic [7:0] v, input logic e);
    wr(ad(IDX_ENABLE_SECOND), v, resp);
    @(posedge core_clk_i);
    por <= 1'b1;
    @(posedge core_clk_i);
    por <= 1'b0;
    settle();
    check(oe, e);
    check(system_on, e);
  endtask : por_case

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk_i);
    failures++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ad(rst_idx[i]), 5'h00, rd_v, resp);
      check(rd_v, {24'h000000, rst_exp[i]});
    end
    // Unmapped place refused without effect
    rd(12'h2d8, 5'h00, rd_v, resp);
    check(resp, RESP_SLVERR);
    wr(12'h2d8, 8'hff, resp);
    check(resp, RESP_SLVERR);
    // Each latched pin with its source still disabled
    for (int k = 0; k < EDGE_N; k++) begin
      fall_pin(k);
      rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
      check(rd_v, 32'h1 << pos[k]);
      rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
      check(rd_v, 32'h0);
      check(oe, 1'b0);
    end
    // Live group levels survive reads
    grp_a <= 1'b1;
    rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
    rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
    check(rd_v, 32'h1 << BIT_GROUP_A);
    grp_a <= 1'b0;
    grp_b <= 1'b1;
    rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
    check(rd_v, 32'h1 << BIT_GROUP_B);
    grp_b <= 1'b0;
    rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
    check(rd_v, 32'h0);
    // Edge on the clearing read edge must survive
    rd(ad(IDX_STATUS_FIRST), 5'h04, rd_v, resp);
    check(rd_v, 32'h0);
    rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
    check(rd_v, 32'h1 << BIT_KBD);
    // Enabled keyboard wake, interrupt raise, mask and clear
    wr(ad(IDX_IRQ_MASK), 8'h07, resp);
    wr(ad(IDX_ENABLE_FIRST), 8'h04, resp);
    fall_pin(2);
    settle();
    check(system_on, 1'b1);
    check(irq, 1'b1);
    rd(ad(IDX_STATUS_FIRST), 5'h00, rd_v, resp);
    check(rd_v, 32'h04);
    rd(ad(IDX_IRQ_STATUS), 5'h00, rd_v, resp);
    check(rd_v, 32'h03);
    wr(ad(IDX_IRQ_MASK), 8'h00, resp);
    settle();
    check(irq, 1'b0);
    wr(ad(IDX_IRQ_STATUS), 8'h03, resp);
    wr(ad(IDX_IRQ_MASK), 8'h07, resp);
    settle();
    check(irq, 1'b0);
    // Button allowed by reset default
    push_button();
    check(system_on, 1'b0);
    rd(ad(IDX_IRQ_STATUS), 5'h00, rd_v, resp);
    check(rd_v, 32'h04);
    wr(ad(IDX_ENABLE_SECOND), 8'h88, resp);
    @(posedge core_clk_i);
    sec_ev <= 8'h08;
    @(posedge core_clk_i);
    sec_ev <= 8'h00;
    settle();
    check(oe, 1'b1);
    rd(ad(IDX_STATUS_SECOND), 5'h00, rd_v, resp);
    check(rd_v, 32'h08);
    rd(ad(IDX_STATUS_SECOND), 5'h00, rd_v, resp);
    check(rd_v, 32'h00);
    por_case(8'h10, 1'b0);
    por_case(8'h00, 1'b0);
    por_case(8'h40, 1'b1);
    por_case(8'h00, 1'b1);
    // Allow bit cleared: button has no say
    push_button();
    check(oe, 1'b1);
    complete_run();
  end
endmodule : soft_power_wake_test
`default_nettype wire

// ### src/soft_power_pkg.sv
// Constants shared by the soft-power wake-event block
package soft_power_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE_FIRST = 8'hb0;
  localparam logic [7:0] IDX_ENABLE_SECOND = 8'hb1;
  localparam logic [7:0] IDX_STATUS_FIRST = 8'hb2;
  localparam logic [7:0] IDX_STATUS_SECOND = 8'hb3;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hb4;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hb5;
  localparam int ADDR_W = 12;
  // Field positions in the first enable and status registers
  localparam int BIT_RING1 = 0;
  localparam int BIT_RING2 = 1;
  localparam int BIT_KBD = 2;
  localparam int BIT_MOUSE = 3;
  localparam int BIT_GROUP_A = 4;
  localparam int BIT_GROUP_B = 5;
  localparam int BIT_IR_RX = 6;
  // Field positions in the second enable register
  localparam int BIT_STAY_OFF = 4;
  localparam int BIT_POWER_UP = 6;
  localparam int BIT_OFF_ALLOW = 7;
  // Writable bits of both enable registers and wake-enable bits of the second enable register
  localparam logic [7:0] WMASK_ENABLE_FIRST = 8'h7f;
  localparam logic [7:0] WMASK_ENABLE_SECOND = 8'hdb;
  localparam logic [7:0] WAKE_MASK_SECOND = 8'h0b;
  // Reset values
  localparam logic [7:0] RST_ENABLE_FIRST = 8'h00;
  localparam logic [7:0] RST_ENABLE_SECOND = 8'h80;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // Interrupt status bits
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_POWER_ON = 1;
  localparam int IRQ_POWER_OFF = 2;
  localparam int IRQ_W = 3;
  // Number of falling-edge latched pins
  localparam int EDGE_N = 5;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : soft_power_pkg

// ### src/soft_power_wake.sv
// Soft-power wake status, power-on request and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module soft_power_wake
  import soft_power_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Wake source pins and internal signals
  input wire logic ring_ind_port1_event_i,
  input wire logic ring_ind_port2_event_i,
  input wire logic kbd_line_event_i,
  input wire logic mouse_line_event_i,
  input wire logic ir_rx_line_event_i,
  input wire logic group_int_a_i,
  input wire logic group_int_b_i,
  input wire logic [7:0] wake_second_event_i,
  // Power control
  input wire logic standby_supply_por_i,
  input wire logic button_off_i,
  output logic power_on_request_n_o,
  output logic power_on_request_oe_o,
  // Interrupt
  output logic irq_o
);
  wake_edge_if edge_if ();

  logic [7:0] en1_r;
  logic [7:0] en2_r;
  logic [7:0] status2_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic irq_r;
  logic pwr_on_r;
  logic pin_level_r;
  logic wake_hit_q;
  // Bus state
  logic awready_r;
  logic wready_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  wake_edge_latch u_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .edge_if(edge_if)
  );

  // Pin order matches flag order 0..4
  assign edge_if.pins = {ir_rx_line_event_i, mouse_line_event_i, kbd_line_event_i,
                         ring_ind_port2_event_i, ring_ind_port1_event_i};

  // status bit placement; live group levels; read leaves them
  wire [7:0] status1_val = {1'b0, edge_if.sticky[4], group_int_b_i, group_int_a_i,
                            edge_if.sticky[3:0]};

  // Address decode on word index
  wire [7:0] ar_idx = s_axi_araddr_i[9:2];
  wire ar_map = (s_axi_araddr_i[ADDR_W-1:10] == '0) &&
                (ar_idx >= IDX_ENABLE_FIRST) && (ar_idx <= IDX_IRQ_MASK);
  wire [7:0] aw_idx = awaddr_r[9:2];
  wire aw_map = (awaddr_r[ADDR_W-1:10] == '0) &&
                (aw_idx >= IDX_ENABLE_FIRST) && (aw_idx <= IDX_IRQ_MASK);

  // Bus handshakes
  wire aw_take = s_axi_awvalid_i & awready_r;
  wire w_take = s_axi_wvalid_i & wready_r;
  wire wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
  wire ar_take = s_axi_arvalid_i & arready_r;
  wire wr_en = wr_do & aw_map & wstrb0_r;
  wire aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_do;
  wire w_hold_nxt = (w_hold_r | w_take) & ~wr_do;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_i);

  // Side effects of access
  wire rd_clr1 = ar_take & ar_map & (ar_idx == IDX_STATUS_FIRST);
  wire rd_clr2 = ar_take & ar_map & (ar_idx == IDX_STATUS_SECOND);
  assign edge_if.clear = rd_clr1;
  wire [IRQ_W-1:0] irq_w1c = (wr_en && aw_idx == IDX_IRQ_STATUS) ? wbyte_r[IRQ_W-1:0] : '0;

  // Read data selection
  // first status read; second status read
  wire [7:0] rd_byte = (ar_idx == IDX_ENABLE_FIRST) ? en1_r :
                       (ar_idx == IDX_ENABLE_SECOND) ? en2_r :
                       (ar_idx == IDX_STATUS_FIRST) ? status1_val :
                       (ar_idx == IDX_STATUS_SECOND) ? status2_r :
                       (ar_idx == IDX_IRQ_STATUS) ? {5'h00, irq_stat_r} :
                       (ar_idx == IDX_IRQ_MASK) ? {5'h00, irq_mask_r} : 8'h00;

  // only enabled sources feed the request
  wire wake_hit = |(status1_val & en1_r & WMASK_ENABLE_FIRST) |
                  |(status2_r & en2_r & WAKE_MASK_SECOND);
  // New wake only; a stale flag must not fight a button power-off
  wire wake_rise = wake_hit & ~wake_hit_q;
  wire power_up_bit = en2_r[BIT_POWER_UP];
  wire stay_off_bit = en2_r[BIT_STAY_OFF];
  wire button_off = button_off_i & en2_r[BIT_OFF_ALLOW];

  // Power-on request next state; standby POR has priority
  logic pwr_on_nxt;
  always_comb begin
    pwr_on_nxt = pwr_on_r;
    if (standby_supply_por_i) begin
      if (power_up_bit) begin
        pwr_on_nxt = 1'b1;
      end else if (stay_off_bit) begin
        pwr_on_nxt = 1'b0;
      end
    end else if (wake_rise) begin
      pwr_on_nxt = 1'b1;
    end else if (button_off) begin
      pwr_on_nxt = 1'b0;
    end
  end

  wire [IRQ_W-1:0] irq_set = {pwr_on_r & ~pwr_on_nxt, ~pwr_on_r & pwr_on_nxt, wake_rise};
  // Set beats the write-one clear
  wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_w1c) | irq_set;

  // Power request and open-drain pin
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pwr_on_r <= 1'b0;
      pin_level_r <= 1'b1;
      wake_hit_q <= 1'b0;
    end else begin
      pwr_on_r <= pwr_on_nxt;
      pin_level_r <= ~pwr_on_nxt;
      wake_hit_q <= wake_hit;
    end
  end

  // Enable registers; allow bit resets to one
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      en1_r <= RST_ENABLE_FIRST;
      en2_r <= RST_ENABLE_SECOND;
      irq_mask_r <= RST_IRQ;
    end else if (wr_en) begin
      if (aw_idx == IDX_ENABLE_FIRST) en1_r <= wbyte_r & WMASK_ENABLE_FIRST;
      if (aw_idx == IDX_ENABLE_SECOND) en2_r <= wbyte_r & WMASK_ENABLE_SECOND;
      if (aw_idx == IDX_IRQ_MASK) irq_mask_r <= wbyte_r[IRQ_W-1:0];
    end
  end

  // Second status and interrupt; zero on reset, set wins
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      status2_r <= RST_STATUS;
      irq_stat_r <= RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      status2_r <= wake_second_event_i | (status2_r & ~{8{rd_clr2}});
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= '0;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt;
      wready_r <= ~w_hold_nxt;
      if (aw_take) awaddr_r <= s_axi_awaddr_i;
      if (w_take) wbyte_r <= s_axi_wdata_i[7:0];
      if (w_take) wstrb0_r <= s_axi_wstrb_i[0];
    end
  end

  // Write response; unmapped address answers SLVERR
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= aw_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel; one read in flight, data frozen while rvalid
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= ar_map ? {24'h000000, rd_byte} : 32'h0000_0000;
        rresp_r <= ar_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Outputs straight from flops
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign power_on_request_oe_o = pwr_on_r;
  assign power_on_request_n_o = pin_level_r;
  assign irq_o = irq_r;

  // Checks
  sequence s_por_up;
    standby_supply_por_i && power_up_bit;
  endsequence
  sequence s_por_off;
    standby_supply_por_i && stay_off_bit && !power_up_bit;
  endsequence

  property p_por_power_up;
    s_por_up |=> power_on_request_oe_o && !power_on_request_n_o;
  endproperty
  a_por_power_up: assert property (p_por_power_up) else $error("no power-up at POR");

  property p_por_stay_off;
    s_por_off |=> !power_on_request_oe_o;
  endproperty
  a_por_stay_off: assert property (p_por_stay_off) else $error("request not floated");

  property p_por_keep;
    (standby_supply_por_i && !stay_off_bit && !power_up_bit) |=> $stable(pwr_on_r);
  endproperty
  a_por_keep: assert property (p_por_keep) else $error("request level lost at POR");

  property p_allow_reset;
    $past(!rst_n_i) |-> en2_r[BIT_OFF_ALLOW];
  endproperty
  a_allow_reset: assert property (p_allow_reset) else $error("off allow not one");

  property p_button_blocked;
    (button_off_i && !en2_r[BIT_OFF_ALLOW] && !standby_supply_por_i && pwr_on_r)
      |=> pwr_on_r;
  endproperty
  a_button_blocked: assert property (p_button_blocked) else $error("button not gated");

  property p_disabled_no_wake;
    (!wake_hit && !standby_supply_por_i) |=> !$rose(pwr_on_r);
  endproperty
  a_disabled_no_wake: assert property (p_disabled_no_wake) else $error("disabled wake");

  // Read returns the group levels of its own edge; the source may drop right after
  property p_group_live;
    rd_clr1 |=> (s_axi_rdata_o[BIT_GROUP_A] == $past(group_int_a_i)) &&
                (s_axi_rdata_o[BIT_GROUP_B] == $past(group_int_b_i));
  endproperty
  a_group_live: assert property (p_group_live) else $error("group bit wrong");

  property p_status_reset;
    $past(!rst_n_i) |-> (status2_r == RST_STATUS && edge_if.sticky == '0);
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not zero");

  property p_rvalid_hold;
    (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
endmodule : soft_power_wake
`default_nettype wire

// ### src/wake_edge_if.sv
// Pin levels, sticky flags and clear between the edge latch and the top
`timescale 1ns/1ps
`default_nettype none
interface wake_edge_if;
  import soft_power_pkg::*;
  logic [EDGE_N-1:0] pins;
  logic [EDGE_N-1:0] sticky;
  logic clear;
  modport latch (input pins, input clear, output sticky);
  modport ctrl (output pins, output clear, input sticky);
endinterface : wake_edge_if
`default_nettype wire

// ### src/wake_edge_latch.sv
// Falling-edge detectors with sticky flags, cleared by a status read
`timescale 1ns/1ps
`default_nettype none
module wake_edge_latch
  import soft_power_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Link to the top
  wake_edge_if.latch edge_if
);
  logic [EDGE_N-1:0] prev_r;
  logic [EDGE_N-1:0] sticky_r;
  logic [EDGE_N-1:0] fall;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  genvar gi;
  generate
    for (gi = 0; gi < EDGE_N; gi++) begin : g_bit
      // High to low on the pin
      assign fall[gi] = prev_r[gi] & ~edge_if.pins[gi];
      // Previous level resets high so a pin that is low out of reset counts as an event
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          prev_r[gi] <= 1'b1;
          sticky_r[gi] <= 1'b0;
        end else begin
          prev_r[gi] <= edge_if.pins[gi];
          // sticky until read; set beats clear
          sticky_r[gi] <= fall[gi] | (sticky_r[gi] & ~edge_if.clear);
        end
      end
    end
  endgenerate

  assign edge_if.sticky = sticky_r;

  // Every edge is caught, even during a clearing read
  property p_edge_caught;
    (fall != '0) |=> ((sticky_r & $past(fall)) == $past(fall));
  endproperty
  a_edge_caught: assert property (p_edge_caught) else $error("falling edge lost");

  // A read with no new edge empties the flags
  property p_read_clears;
    (edge_if.clear && fall == '0) |=> (sticky_r == '0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");
endmodule : wake_edge_latch
`default_nettype wire
